// >>> common/nco_regs_cfg.svh
`ifndef NCO_REGS_CFG_SVH
`define NCO_REGS_CFG_SVH

// Register offsets
`define ADDR_TW0 8'h30
`define ADDR_TW1 8'h31
`define ADDR_TW2 8'h32
`define ADDR_TW3 8'h33
`define ADDR_PH_LO 8'h34
`define ADDR_PH_HI 8'h35
`define ADDR_UPD 8'h36
`define ADDR_IPC_LO 8'h38
`define ADDR_IPC_HI 8'h39
`define ADDR_QPC_LO 8'h3a
`define ADDR_QPC_HI 8'h3b
`define ADDR_IDC_LO 8'h3c
`define ADDR_IDC_HI 8'h3d
`define ADDR_QDC_LO 8'h3e
`define ADDR_QDC_HI 8'h3f
`define ADDR_IFS_LO 8'h40
`define ADDR_ICTL 8'h41
`define ADDR_IAUX_LO 8'h42

// Update control fields
`define UPD_REQ_BIT 0
`define UPD_ACK_BIT 1
`define RSY_REQ_BIT 4
`define RSY_ACK_BIT 5

// Converter control fields
`define ICTL_SLEEP_BIT 7
`define ICTL_FS_MSB 1

// Reset values
`define RST_FS_LO 8'hf9
`define RST_FS_HI 2'h1

`endif

// >>> common/nco_regs_pkg.sv
package nco_regs_pkg;

   typedef enum logic [0:0] {RS_IDLE, RS_ARMED} resync_e;

   typedef logic [7:0] byte_t;

   typedef struct packed {
      logic [31:0] stagedTw;
      logic [31:0] activeTw;
      logic [31:0] phaseAcc;
      logic [15:0] phaseOff;
      logic updReq;
      logic updAck;
      logic rsyReq;
      logic rsyAck;
      resync_e rsyState;
      logic [7:0] markerCnt;
      logic [9:0] iCorr;
      logic [9:0] qCorr;
      logic [15:0] iDc;
      logic [15:0] qDc;
      logic [7:0] fsLow;
      logic [1:0] fsHigh;
      logic iSleep;
      logic [7:0] auxLow;
      byte_t rdData;
      logic rdValid;
      logic [15:0] iSample;
      logic [15:0] qSample;
      logic [15:0] phaseI;
      logic [15:0] phaseQ;
   } regs_s;

endpackage

// >>> hdl/nco_tuning_and_dac_trim_regs.sv
`include "nco_regs_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module nco_tuning_and_dac_trim_regs #(
   parameter int MARKER_EXT_CYCLES = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Register port
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regAddr,
   input wire nco_regs_pkg::byte_t regWrData,
   output nco_regs_pkg::byte_t regRdData,
   output logic regRdValid,
   // Sync marker
   input wire logic syncMarker,
   // Sample path
   input wire logic [15:0] iSampleIn,
   input wire logic [15:0] qSampleIn,
   output logic [15:0] iSampleOut,
   output logic [15:0] qSampleOut,
   // Oscillator
   output logic [31:0] oscPhase,
   output logic [15:0] oscPhaseI,
   output logic [15:0] oscPhaseQ,
   output logic [31:0] activeTuningWord,
   // Converter trims
   input wire logic [1:0] iAuxLevelHigh,
   output logic [9:0] iFullScaleCode,
   output logic iConverterSleep,
   output logic [9:0] iAuxLevel
);
   import nco_regs_pkg::*;

   // ************************************************
   // State
   // ************************************************
   localparam logic [7:0] MARKER_LAST = 8'(MARKER_EXT_CYCLES - 1);

   regs_s st;
   regs_s next_st;

   logic wrHit;
   logic markerFire;
   logic updRise;
   logic rsyRise;
   logic [15:0] iCorrExt;
   logic [15:0] qCorrExt;

   assign wrHit = regWrEn && (regAddr == `ADDR_UPD);
   assign updRise = wrHit && regWrData[`UPD_REQ_BIT] && !st.updReq;
   assign rsyRise = wrHit && regWrData[`RSY_REQ_BIT] && !st.rsyReq;
   assign markerFire = syncMarker && (st.markerCnt == MARKER_LAST);
   assign iCorrExt = {{6{st.iCorr[9]}}, st.iCorr};
   assign qCorrExt = {{6{st.qCorr[9]}}, st.qCorr};

   // ************************************************
   // Next state
   // ************************************************
   always_comb begin
      next_st = st;
      next_st.rdValid = 1'b0;

      // Register writes
      if (regWrEn) begin
         if (regAddr == `ADDR_TW0) begin
            next_st.stagedTw[7:0] = regWrData;
         end else if (regAddr == `ADDR_TW1) begin
            next_st.stagedTw[15:8] = regWrData;
         end else if (regAddr == `ADDR_TW2) begin
            next_st.stagedTw[23:16] = regWrData;
         end else if (regAddr == `ADDR_TW3) begin
            next_st.stagedTw[31:24] = regWrData;
         end else if (regAddr == `ADDR_PH_LO) begin
            next_st.phaseOff[7:0] = regWrData;
         end else if (regAddr == `ADDR_PH_HI) begin
            next_st.phaseOff[15:8] = regWrData;
         end else if (regAddr == `ADDR_UPD) begin
            next_st.updReq = regWrData[`UPD_REQ_BIT];
            next_st.rsyReq = regWrData[`RSY_REQ_BIT];
            if (!regWrData[`UPD_REQ_BIT]) begin
               next_st.updAck = 1'b0;
            end
            if (!regWrData[`RSY_REQ_BIT]) begin
               next_st.rsyAck = 1'b0;
            end
         end else if (regAddr == `ADDR_IPC_LO) begin
            next_st.iCorr[7:0] = regWrData;
         end else if (regAddr == `ADDR_IPC_HI) begin
            next_st.iCorr[9:8] = regWrData[1:0];
         end else if (regAddr == `ADDR_QPC_LO) begin
            next_st.qCorr[7:0] = regWrData;
         end else if (regAddr == `ADDR_QPC_HI) begin
            next_st.qCorr[9:8] = regWrData[1:0];
         end else if (regAddr == `ADDR_IDC_LO) begin
            next_st.iDc[7:0] = regWrData;
         end else if (regAddr == `ADDR_IDC_HI) begin
            next_st.iDc[15:8] = regWrData;
         end else if (regAddr == `ADDR_QDC_LO) begin
            next_st.qDc[7:0] = regWrData;
         end else if (regAddr == `ADDR_QDC_HI) begin
            next_st.qDc[15:8] = regWrData;
         end else if (regAddr == `ADDR_IFS_LO) begin
            next_st.fsLow = regWrData;
         end else if (regAddr == `ADDR_ICTL) begin
            next_st.iSleep = regWrData[`ICTL_SLEEP_BIT];
            next_st.fsHigh = regWrData[`ICTL_FS_MSB:0];
         end else if (regAddr == `ADDR_IAUX_LO) begin
            next_st.auxLow = regWrData;
         end
      end

      // Register reads, one cycle later
      if (regRdEn) begin
         next_st.rdValid = 1'b1;
         if (regAddr == `ADDR_TW0) begin
            next_st.rdData = st.stagedTw[7:0];
         end else if (regAddr == `ADDR_TW1) begin
            next_st.rdData = st.stagedTw[15:8];
         end else if (regAddr == `ADDR_TW2) begin
            next_st.rdData = st.stagedTw[23:16];
         end else if (regAddr == `ADDR_TW3) begin
            next_st.rdData = st.stagedTw[31:24];
         end else if (regAddr == `ADDR_PH_LO) begin
            next_st.rdData = st.phaseOff[7:0];
         end else if (regAddr == `ADDR_PH_HI) begin
            next_st.rdData = st.phaseOff[15:8];
         end else if (regAddr == `ADDR_UPD) begin
            next_st.rdData = 8'h00;
            next_st.rdData[`UPD_REQ_BIT] = st.updReq;
            next_st.rdData[`UPD_ACK_BIT] = st.updAck;
            next_st.rdData[`RSY_REQ_BIT] = st.rsyReq;
            next_st.rdData[`RSY_ACK_BIT] = st.rsyAck;
         end else if (regAddr == `ADDR_IPC_LO) begin
            next_st.rdData = st.iCorr[7:0];
         end else if (regAddr == `ADDR_IPC_HI) begin
            next_st.rdData = {6'h00, st.iCorr[9:8]};
         end else if (regAddr == `ADDR_QPC_LO) begin
            next_st.rdData = st.qCorr[7:0];
         end else if (regAddr == `ADDR_QPC_HI) begin
            next_st.rdData = {6'h00, st.qCorr[9:8]};
         end else if (regAddr == `ADDR_IDC_LO) begin
            next_st.rdData = st.iDc[7:0];
         end else if (regAddr == `ADDR_IDC_HI) begin
            next_st.rdData = st.iDc[15:8];
         end else if (regAddr == `ADDR_QDC_LO) begin
            next_st.rdData = st.qDc[7:0];
         end else if (regAddr == `ADDR_QDC_HI) begin
            next_st.rdData = st.qDc[15:8];
         end else if (regAddr == `ADDR_IFS_LO) begin
            next_st.rdData = st.fsLow;
         end else if (regAddr == `ADDR_ICTL) begin
            next_st.rdData = 8'h00;
            next_st.rdData[`ICTL_SLEEP_BIT] = st.iSleep;
            next_st.rdData[`ICTL_FS_MSB:0] = st.fsHigh;
         end else if (regAddr == `ADDR_IAUX_LO) begin
            next_st.rdData = st.auxLow;
         end else begin
            next_st.rdData = 8'h00;
         end
      end

      // ************************************************
      // Tuning word update
      // ************************************************
      if (updRise) begin
         next_st.activeTw = st.stagedTw;
         next_st.updAck = 1'b1;
      end

      // ************************************************
      // Marker pulse length
      // ************************************************
      if (!syncMarker) begin
         next_st.markerCnt = 8'h00;
      end else if (st.markerCnt <= MARKER_LAST) begin
         next_st.markerCnt = 8'(st.markerCnt + 8'h01);
      end

      // ************************************************
      // Resync and oscillator
      // ************************************************
      next_st.phaseAcc = 32'(st.phaseAcc + st.activeTw);
      case (st.rsyState)
         RS_IDLE: begin
            if (rsyRise) begin
               next_st.rsyState = RS_ARMED;
            end
         end
         RS_ARMED: begin
            if (markerFire) begin
               next_st.rsyState = RS_IDLE;
               next_st.phaseAcc = {st.phaseOff, 16'h0000};
               next_st.rsyAck = 1'b1;
            end
         end
         default: begin
            next_st.rsyState = RS_IDLE;
         end
      endcase

      // ************************************************
      // Sample and phase outputs
      // ************************************************
      next_st.iSample = 16'(iSampleIn + st.iDc);
      next_st.qSample = 16'(qSampleIn + st.qDc);
      next_st.phaseI = 16'(st.phaseAcc[31:16] + iCorrExt);
      next_st.phaseQ = 16'(st.phaseAcc[31:16] + qCorrExt);
   end

   // ************************************************
   // Registers
   // ************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
         st.rsyState <= RS_IDLE;
         st.fsLow <= `RST_FS_LO;
         st.fsHigh <= `RST_FS_HI;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************
   // Outputs
   // ************************************************
   assign regRdData = st.rdData;
   assign regRdValid = st.rdValid;
   assign iSampleOut = st.iSample;
   assign qSampleOut = st.qSample;
   assign oscPhase = st.phaseAcc;
   assign oscPhaseI = st.phaseI;
   assign oscPhaseQ = st.phaseQ;
   assign activeTuningWord = st.activeTw;
   assign iFullScaleCode = {st.fsHigh, st.fsLow};
   assign iConverterSleep = st.iSleep;
   assign iAuxLevel = {iAuxLevelHigh, st.auxLow};

endmodule

`default_nettype wire

// >>> dv/nco_trim_regs_props.sv
`timescale 1ns/1ns
`default_nettype none
module nco_trim_regs_props (
   // Clock, reset, register port
   input wire logic clk, arst_n, regWrEn, regRdEn, regRdValid,
   input wire logic [7:0] regAddr,
   input wire nco_regs_pkg::byte_t regWrData,
   // Datapath and trims
   input wire logic syncMarker, iConverterSleep,
   input wire logic [15:0] iSampleIn, iSampleOut,
   input wire logic [31:0] oscPhase, activeTuningWord,
   input wire logic [1:0] iAuxLevelHigh,
   input wire logic [9:0] iFullScaleCode, iAuxLevel
);
   import nco_regs_pkg::*;
   // ****
   // Checks
   // ****
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   rd_valid_a: assert property (regRdEn |=> regRdValid)
      else $error("read valid missing");
   tw_hold_a: assert property ($changed(activeTuningWord) |->
      $past(regWrEn && regAddr == 8'h36 && regWrData[0])) else $error("tuning word moved without request");
   acc_step_a: assert property (!$past(syncMarker) && !$past(syncMarker, 2) |->
      oscPhase == $past(oscPhase) + $past(activeTuningWord)) else $error("phase step wrong");
   fs_low_a: assert property (regWrEn && regAddr == 8'h40 |=> iFullScaleCode[7:0] == $past(regWrData))
      else $error("full scale low wrong");
   fs_hold_a: assert property ($changed(iFullScaleCode) |-> $past(regWrEn) &&
      ($past(regAddr) == 8'h40 || $past(regAddr) == 8'h41)) else $error("full scale moved");
   sleep_bit_a: assert property (regWrEn && regAddr == 8'h41 |=> iConverterSleep == $past(regWrData[7]))
      else $error("sleep bit wrong");
   aux_low_a: assert property (regWrEn && regAddr == 8'h42 |=> iAuxLevel[7:0] == $past(regWrData))
      else $error("aux low wrong");
   aux_high_a: assert property (iAuxLevel[9:8] == iAuxLevelHigh)
      else $error("aux high wrong");
   sample_step_a: assert property ($past(arst_n, 2) && !$past(regWrEn) && !$past(regWrEn, 2) |->
      iSampleOut - $past(iSampleIn) == $past(iSampleOut) - $past(iSampleIn, 2)) else $error("sample offset wrong");
   cover property (regWrEn && regAddr == 8'h36 && regWrData[4]);
   cover property ($changed(activeTuningWord));
   cover property (syncMarker [*2]);
endmodule
bind nco_tuning_and_dac_trim_regs nco_trim_regs_props u_props (.clk, .arst_n, .regWrEn, .regRdEn, .regRdValid,
   .regAddr, .regWrData, .syncMarker, .iConverterSleep, .iSampleIn, .iSampleOut, .oscPhase, .activeTuningWord,
   .iAuxLevelHigh, .iFullScaleCode, .iAuxLevel);
`default_nettype wire

// >>> dv/nco_tuning_and_dac_trim_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module nco_tuning_and_dac_trim_regs_tb_top;
   import nco_regs_pkg::*;
   logic clk = 0, arst_n = 0, regWrEn = 0, regRdEn = 0, syncMarker = 0, regRdValid, iConverterSleep;
   logic [7:0] regAddr = 0;
   byte_t regWrData = 0, regRdData;
   logic [15:0] iSampleIn = 0, qSampleIn = 0, iSampleOut, qSampleOut, oscPhaseI, oscPhaseQ;
   logic [31:0] oscPhase, activeTuningWord, p;
   logic [1:0] iAuxLevelHigh = 0;
   logic [9:0] iFullScaleCode, iAuxLevel;
   byte_t wv [0:255];
   byte_t q [$];
   int error_cnt = 0, tests_run = 0;
   integer seed = 32'h8ff31872;
   // ****
   // Stimulus and checking
   // ****
   always #2 clk = ~clk;
   nco_tuning_and_dac_trim_regs #(.MARKER_EXT_CYCLES(2)) uut (.clk, .arst_n, .regWrEn, .regRdEn, .regAddr,
      .regWrData, .regRdData, .regRdValid, .syncMarker, .iSampleIn, .qSampleIn, .iSampleOut, .qSampleOut,
      .oscPhase, .oscPhaseI, .oscPhaseQ, .activeTuningWord, .iAuxLevelHigh, .iFullScaleCode, .iConverterSleep,
      .iAuxLevel);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Write when w is set, else read and note the expected data
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      if (!w) q.push_back(d);
      @(posedge clk);
      #1 {regWrEn, regRdEn, regAddr, regWrData} = {w, !w, a, d};
      @(posedge clk);
      #1 {regWrEn, regRdEn} = 2'b00;
   endtask
   function automatic logic [7:0] msk(input int a);
      return (a == 8'h39 || a == 8'h3b) ? 8'h03 : a == 8'h41 ? 8'h83 : a == 8'h37 ? 8'h00 : 8'hff;
   endfunction
   task wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) if (regRdValid === 1'b1) chk(regRdData, q.pop_front());
   initial begin
      #20000;
      error_cnt++;
      wrap_up;
   end
   initial begin
      repeat (4) @(posedge clk);
      #1 arst_n = 1;
      for (int a = 8'h30; a <= 8'h43; a++) acc(0, 8'(a), a == 8'h40 ? 8'hf9 : a == 8'h41 ? 8'h01 : 8'h00);
      for (int a = 8'h30; a <= 8'h42; a++) begin
         wv[a] = 8'($random(seed));
         if (a != 8'h36) acc(1, 8'(a), wv[a]);
      end
      for (int a = 8'h30; a <= 8'h42; a++) if (a != 8'h36) acc(0, 8'(a), wv[a] & msk(a));
      iAuxLevelHigh = 2'($random(seed));
      #1 chk(iFullScaleCode, {wv[8'h41][1:0], wv[8'h40]});
      chk(iConverterSleep, wv[8'h41][7]);
      chk(iAuxLevel, {iAuxLevelHigh, wv[8'h42]});
      chk(activeTuningWord, 0);
      acc(1, 8'h36, 8'h01);
      chk(activeTuningWord, {wv[8'h33], wv[8'h32], wv[8'h31], wv[8'h30]});
      acc(0, 8'h36, 8'h03);
      repeat (8) begin
         {iSampleIn, qSampleIn} = $random(seed);
         p = oscPhase;
         @(posedge clk);
         #1 chk(iSampleOut, 16'(iSampleIn + {wv[8'h3d], wv[8'h3c]}));
         chk(qSampleOut, 16'(qSampleIn + {wv[8'h3f], wv[8'h3e]}));
         chk(oscPhaseI, 16'(p[31:16] + {{6{wv[8'h39][1]}}, wv[8'h39][1:0], wv[8'h38]}));
         chk(oscPhaseQ, 16'(p[31:16] + {{6{wv[8'h3b][1]}}, wv[8'h3b][1:0], wv[8'h3a]}));
      end
      p = activeTuningWord;
      acc(1, 8'h30, ~wv[8'h30]);
      acc(1, 8'h36, 8'h01);
      chk(activeTuningWord, p);
      acc(1, 8'h36, 8'h00);
      acc(0, 8'h36, 8'h00);
      for (int a = 8'h30; a < 8'h34; a++) acc(1, 8'(a), 8'h00);
      acc(1, 8'h36, 8'h01);
      acc(1, 8'h36, 8'h11);
      p = oscPhase;
      syncMarker = 1;
      @(posedge clk);
      #1 syncMarker = 0;
      repeat (3) @(posedge clk);
      #1 chk(oscPhase, p);
      syncMarker = 1;
      repeat (2) @(posedge clk);
      #1 syncMarker = 0;
      repeat (2) @(posedge clk);
      #1 chk(oscPhase, {wv[8'h35], wv[8'h34], 16'h0000});
      acc(0, 8'h36, 8'h33);
      @(posedge clk);
      #1 chk(q.size(), 0);
      wrap_up;
   end
endmodule
`default_nettype wire
